//--- hdl/ssem_defines.svh
// Constants of the supply supervisor event mask block
// Overview of operation
// - Full-performance re-enable masks events for 2 us
// - Mask length depends on the performance mode
// - Separate high and low comparator event paths
// - Unmasked detection sets the matching event flag
// - Detection raises reset only when enabled
// - Pins float while flags pending, until settled
// - Keep-on bit 0 turns comparators off deeply
// - Keep-on bit resets to zero
// - Short mask lets unsettled wake trips flag
// - Reset enables comparators without starting mask
// - Normal low side holds CPU 150 us after LPM3/LPM4 wake
`ifndef SSEM_DEFINES_SVH
`define SSEM_DEFINES_SVH

// Register byte offsets
`define SSEM_CTRL_OFS 12'h000
`define SSEM_STATUS_OFS 12'h004
`define SSEM_IEN_OFS 12'h008
`define SSEM_STATE_OFS 12'h00C

// Per-comparator control nibble: high side [3:0], low side [7:4]
`define SSEM_CFG_W 4
`define SSEM_CTRL_RESET 8'h11
`define SSEM_STATUS_RESET 2'h0
`define SSEM_IEN_RESET 2'h0

// Comparator index
`define SSEM_HIGH 0
`define SSEM_LOW 1

// Low-power mode codes
`define SSEM_LPM_ACTIVE 3'h0
`define SSEM_LPM2 3'h2
`define SSEM_LPM3 3'h3
`define SSEM_LPM4 3'h4

// Timing
`define SSEM_CLK_NS 10
`define SSEM_FP_MASK_NS 2000
`define SSEM_NM_MASK_NS 150000
`define SSEM_SETTLE_NS 10000
`define SSEM_HOLD_NS 150000
`define SSEM_FP_MASK_CYC \
    ((`SSEM_FP_MASK_NS + `SSEM_CLK_NS - 1) / `SSEM_CLK_NS)
`define SSEM_NM_MASK_CYC \
    ((`SSEM_NM_MASK_NS + `SSEM_CLK_NS - 1) / `SSEM_CLK_NS)
`define SSEM_SETTLE_CYC \
    ((`SSEM_SETTLE_NS + `SSEM_CLK_NS - 1) / `SSEM_CLK_NS)
`define SSEM_HOLD_CYC \
    ((`SSEM_HOLD_NS + `SSEM_CLK_NS - 1) / `SSEM_CLK_NS)

`endif

//--- hdl/ssem_mask_timer.sv
// Settling mask and settle timer for one supervisor comparator
`timescale 1ns/10ps
`include "ssem_defines.svh"

module ssem_mask_timer #(
    parameter int CW = 16,
    parameter logic [15:0] MASK_FP_CYC = 16'(`SSEM_FP_MASK_CYC),
    parameter logic [15:0] MASK_NM_CYC = 16'(`SSEM_NM_MASK_CYC),
    parameter logic [15:0] SETTLE_CYC = 16'(`SSEM_SETTLE_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enabled,
    input wire logic restart,
    input wire logic full_perf,
    output logic masking,
    output logic settled
);
    logic [CW-1:0] cnt;
    logic [CW-1:0] term;
    logic armed;

    // Terminal count picked by performance mode
    assign term = full_perf ? CW'(MASK_FP_CYC)
                            : CW'(MASK_NM_CYC);

    // Settle counter, cleared on each enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (!enabled || restart) begin
            cnt <= '0;
        end else if (cnt != '1) begin
            cnt <= cnt + CW'(1);
        end
    end

    // Mask only runs after a real enable edge, not after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
        end else if (restart) begin
            armed <= 1'b1;
        end else if (!enabled || cnt >= term) begin
            armed <= 1'b0;
        end
    end

    // Mask window and settled state
    assign masking = armed && (cnt < term);
    assign settled = enabled && (cnt >= CW'(SETTLE_CYC));

    property p_restart_clears;
        @(posedge pclk) disable iff (!presetn)
        restart && enabled |=> cnt == '0;
    endproperty
    a_restart_clears: assert property (p_restart_clears)
        else $error("counter not cleared on enable");

    property p_fp_mask_len;
        @(posedge pclk) disable iff (!presetn)
        restart && enabled && full_perf && (MASK_FP_CYC == 16'd200)
        ##1 (enabled && full_perf) [*8] |-> masking;
    endproperty
    a_fp_mask_len: assert property (p_fp_mask_len)
        else $error("full performance mask ended early");

    property p_mask_bound;
        @(posedge pclk) disable iff (!presetn)
        $fell(masking) && $past(enabled) && $stable(full_perf)
        |-> cnt == term;
    endproperty
    a_mask_bound: assert property (p_mask_bound)
        else $error("mask active past its terminal count");

endmodule : ssem_mask_timer

//--- hdl/ssem_pkg.sv
// Types of the supply supervisor event mask block
package ssem_pkg;

    // Control nibble of one comparator
    typedef struct packed {
        logic keep_on;
        logic full_perf;
        logic reset_enable;
        logic enable;
    } ssem_cfg_t;

    // CPU hold-off sequencer states, Gray along the path
    typedef enum logic [1:0] {
        HOLD_IDLE = 2'b00,
        HOLD_ARMED = 2'b01,
        HOLD_BUSY = 2'b11
    } ssem_hold_t;

endpackage : ssem_pkg

//--- hdl/ssem_top.sv
// Supply supervisor event logic with APB registers
`timescale 1ns/10ps
`include "ssem_defines.svh"

module ssem_top
    import ssem_pkg::*;
#(
    parameter logic [15:0] MASK_NM_CYC = 16'(`SSEM_NM_MASK_CYC),
    parameter logic [15:0] SETTLE_CYC = 16'(`SSEM_SETTLE_CYC),
    parameter logic [15:0] HOLD_CYC = 16'(`SSEM_HOLD_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] cmp_trip,
    input wire logic [2:0] lp_mode,
    output logic [1:0] cmp_en,
    output logic [1:0] cmp_full_perf,
    output logic por_request,
    output logic gpio_hiz,
    output logic cpu_hold,
    output logic irq
);
    ssem_cfg_t cfg [2];
    logic [1:0] flags;
    logic [1:0] ien;
    logic [1:0] trip_meta;
    logic [1:0] trip_sync;
    logic [1:0] on_now;
    logic [1:0] restart;
    logic [1:0] masking;
    logic [1:0] settled;
    logic [1:0] detect;
    logic [1:0] read_clear;
    logic [1:0] next_flags;
    logic deep_lp;
    logic wake_from_deep;
    logic [2:0] lp_q;
    logic access;
    logic done;
    logic [31:0] rd_value;
    logic mapped;
    ssem_hold_t hold_state;
    logic [15:0] hold_cnt;
    logic first_cycle;

    // Deep low-power decode, used for entry and wake detection
    function automatic logic is_deep(input logic [2:0] mode);
        return mode == `SSEM_LPM2 || mode == `SSEM_LPM3
            || mode == `SSEM_LPM4;
    endfunction : is_deep

    // Modes in which the low side holds the CPU on wake
    function automatic logic is_lpm34(input logic [2:0] mode);
        return mode == `SSEM_LPM3 || mode == `SSEM_LPM4;
    endfunction : is_lpm34

    assign deep_lp = is_deep(lp_mode);
    assign wake_from_deep = is_deep(lp_q) && !is_deep(lp_mode);

    // Two-stage synchroniser for the analog comparator outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_meta <= 2'h0;
            trip_sync <= 2'h0;
        end else begin
            trip_meta <= cmp_trip;
            trip_sync <= trip_meta;
        end
    end

    // Previous low-power mode, to spot the wake edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_q <= `SSEM_LPM_ACTIVE;
        end else begin
            lp_q <= lp_mode;
        end
    end

    // Per-comparator enable, mask timer and detection
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cmp
            assign on_now[gi] = cfg[gi].enable
                && !(deep_lp && !cfg[gi].keep_on);
            assign restart[gi] = on_now[gi] && !cmp_en[gi];
            assign detect[gi] = trip_sync[gi] && cmp_en[gi]
                && !masking[gi];

            ssem_mask_timer #(
                .CW(16),
                .MASK_FP_CYC(16'(`SSEM_FP_MASK_CYC)),
                .MASK_NM_CYC(MASK_NM_CYC),
                .SETTLE_CYC(SETTLE_CYC)
            ) u_timer (
                .pclk(pclk),
                .presetn(presetn),
                .enabled(on_now[gi]),
                .restart(restart[gi]),
                .full_perf(cfg[gi].full_perf),
                .masking(masking[gi]),
                .settled(settled[gi])
            );
        end
    endgenerate

    // Comparator drive: on after reset, off in deep modes unless keep-on is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_en <= 2'h3;
            cmp_full_perf <= 2'h0;
        end else begin
            cmp_en <= on_now;
            cmp_full_perf <= {cfg[1].full_perf, cfg[0].full_perf};
        end
    end

    // APB handshake: one wait state, then ready
    assign access = psel && penable;
    assign done = access && pready;

    always_comb begin
        mapped = 1'b1;
        rd_value = 32'h0000_0000;
        case (paddr)
            `SSEM_CTRL_OFS: rd_value = {24'h000000, cfg[1], cfg[0]};
            `SSEM_STATUS_OFS: rd_value = {30'h0, flags};
            `SSEM_IEN_OFS: rd_value = {30'h0, ien};
            `SSEM_STATE_OFS: rd_value = {24'h000000, cpu_hold, gpio_hiz,
                settled, masking, cmp_en};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (access && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? 32'h0000_0000 : rd_value;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cfg[1], cfg[0]} <= `SSEM_CTRL_RESET;
            ien <= `SSEM_IEN_RESET;
        end else if (done && pwrite) begin
            if (paddr == `SSEM_CTRL_OFS) begin
                {cfg[1], cfg[0]} <= pwdata[7:0];
            end
            if (paddr == `SSEM_IEN_OFS) begin
                ien <= pwdata[1:0];
            end
        end
    end

    // Event flags: read clears only the bits returned, set wins
    assign read_clear = (done && !pwrite && paddr == `SSEM_STATUS_OFS)
        ? prdata[1:0] : 2'h0;
    assign next_flags = (flags & ~read_clear) | detect;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= `SSEM_STATUS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // Reset request, interrupt and pin float
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_request <= 1'b0;
            irq <= 1'b0;
            gpio_hiz <= 1'b0;
        end else begin
            por_request <= |(detect & {cfg[1].reset_enable,
                cfg[0].reset_enable});
            irq <= |(next_flags & ien);
            gpio_hiz <= |next_flags
                && ((settled & on_now) != on_now);
        end
    end

    // CPU hold-off after LPM3 or LPM4 sleep with low side in normal mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_state <= HOLD_IDLE;
            hold_cnt <= 16'h0000;
            cpu_hold <= 1'b0;
        end else begin
            case (hold_state)
                HOLD_IDLE: begin
                    if (is_lpm34(lp_mode) && cfg[`SSEM_LOW].enable
                        && !cfg[`SSEM_LOW].full_perf) begin
                        hold_state <= HOLD_ARMED;
                    end
                end
                HOLD_ARMED: begin
                    if (wake_from_deep) begin
                        hold_state <= HOLD_BUSY;
                        hold_cnt <= HOLD_CYC - 16'h0001;
                        cpu_hold <= 1'b1;
                    end
                end
                HOLD_BUSY: begin
                    if (hold_cnt == 16'h0000) begin
                        hold_state <= HOLD_IDLE;
                        cpu_hold <= 1'b0;
                    end else begin
                        hold_cnt <= hold_cnt - 16'h0001;
                    end
                end
                default: begin
                    hold_state <= HOLD_IDLE;
                    cpu_hold <= 1'b0;
                end
            endcase
        end
    end

    // First cycle after reset release, for checking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    property p_reset_defaults;
        @(posedge pclk) disable iff (!presetn)
        first_cycle |-> !cfg[0].keep_on && !cfg[1].keep_on
            && cmp_en == 2'h3 && masking == 2'h0;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("wrong comparator state after reset");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        detect[0] || detect[1] |=> (flags & $past(detect)) == $past(detect);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("detection did not set its flag");

    property p_no_event_masked;
        @(posedge pclk) disable iff (!presetn)
        $rose(flags[0]) |-> $past(trip_sync[0]) && !$past(masking[0]);
    endproperty
    a_no_event_masked: assert property (p_no_event_masked)
        else $error("high flag set while masked");

    property p_por_cause;
        @(posedge pclk) disable iff (!presetn)
        por_request |-> ($past(detect[0]) && $past(cfg[0].reset_enable))
            || ($past(detect[1]) && $past(cfg[1].reset_enable));
    endproperty
    a_por_cause: assert property (p_por_cause)
        else $error("reset request without enabled detection");

    property p_hiz_needs_flag;
        @(posedge pclk) disable iff (!presetn)
        gpio_hiz |-> flags != 2'h0;
    endproperty
    a_hiz_needs_flag: assert property (p_hiz_needs_flag)
        else $error("pins floated with no flag pending");

    property p_deep_off;
        @(posedge pclk) disable iff (!presetn)
        deep_lp && !cfg[1].keep_on |=> !cmp_en[1];
    endproperty
    a_deep_off: assert property (p_deep_off)
        else $error("low comparator left on in deep mode");

    property p_hold_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(cpu_hold) |-> hold_cnt == HOLD_CYC - 16'h0001
            ##1 cpu_hold [*8];
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("CPU hold-off too short");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        ##1 irq == |($past(next_flags) & $past(ien));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt does not follow flags and mask");

    c_high_event: cover property (@(posedge pclk) disable iff (!presetn)
        detect[0] && cfg[0].full_perf);
    c_por: cover property (@(posedge pclk) disable iff (!presetn)
        por_request);
    c_wake_restart: cover property (@(posedge pclk) disable iff (!presetn)
        wake_from_deep && restart[1]);
    c_hold: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(cpu_hold));

endmodule : ssem_top

//--- verification/ssem_cmp_model.sv
// Behavioural model of the two supply supervisor comparators
`timescale 1ns/10ps

module ssem_cmp_model #(
    parameter int SETTLE = 300
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] cmp_en,
    input wire logic [1:0] cmp_full_perf,
    input wire logic [1:0] supply_low,
    input wire logic false_wake,
    output logic [1:0] cmp_trip
);
    logic [1:0] en_q;
    logic tog;
    int age [2];

    // Settling age restarts whenever a comparator is switched on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 2'h3;
            tog <= 1'b0;
            age <= '{0, 0};
        end else begin
            en_q <= cmp_en;
            tog <= ~tog;
            for (int i = 0; i < 2; i++) begin
                if (cmp_en[i] && !en_q[i])
                    age[i] <= 0;
                else if (age[i] < SETTLE)
                    age[i] <= age[i] + 1;
            end
        end
    end

    // Off gives noise; an unsettled full-speed comparator may trip falsely
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!cmp_en[i])
                cmp_trip[i] = tog ^ i[0];
            else
                cmp_trip[i] = supply_low[i] || (false_wake &&
                    cmp_full_perf[i] && age[i] < SETTLE);
        end
    end
endmodule : ssem_cmp_model

//--- verification/ssem_top_tb.sv
// Self-checking testbench of the supply supervisor event block
`timescale 1ns/10ps
`include "ssem_defines.svh"

module ssem_top_tb;
    localparam int MASK_NM = 40;
    localparam int FP_MASK = 200;
    localparam int SETTLE = 300;
    localparam int HOLD = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] supply_low = 2'h0;
    logic false_wake = 1'b0;
    logic [2:0] lp_mode = 3'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, por_request, gpio_hiz, cpu_hold, irq, e;
    logic [1:0] cmp_trip, cmp_en, cmp_full_perf;
    logic en0_q = 1'b0;
    logic irq_q = 1'b0;
    logic [31:0] rs = 32'h12;
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    int en_rise = 0;
    int irq_rise = 0;
    int por_cnt = 0;
    int n, lat;

    always #5 pclk = ~pclk;

    // Cycle stamps of comparator enable and interrupt edges
    always @(posedge pclk) begin
        cyc++;
        en0_q <= cmp_en[0];
        irq_q <= irq;
        if (cmp_en[0] && !en0_q) en_rise = cyc;
        if (irq && !irq_q) irq_rise = cyc;
        if (por_request) por_cnt++;
    end

    ssem_top #(.MASK_NM_CYC(16'h0028), .SETTLE_CYC(16'h012C),
        .HOLD_CYC(16'h0014)) ssem_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_trip(cmp_trip),
        .lp_mode(lp_mode), .cmp_en(cmp_en), .cmp_full_perf(cmp_full_perf),
        .por_request(por_request), .gpio_hiz(gpio_hiz),
        .cpu_hold(cpu_hold), .irq(irq));

    ssem_cmp_model #(.SETTLE(SETTLE)) ssem_cmp_model_inst (
        .pclk(pclk), .presetn(presetn), .cmp_en(cmp_en),
        .cmp_full_perf(cmp_full_perf), .supply_low(supply_low),
        .false_wake(false_wake), .cmp_trip(cmp_trip));

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs

    function automatic int mask_len(input logic fp);
        return fp ? FP_MASK : MASK_NM;
    endfunction : mask_len

    function automatic logic [31:0] ctrl(input logic [3:0] hi,
        input logic [3:0] lo);
        return {24'h0, lo, hi};
    endfunction : ctrl

    function automatic logic pick(input int s);
        case (s)
            0: return irq;
            1: return gpio_hiz;
            default: return cpu_hold;
        endcase
    endfunction : pick

    task automatic end_of_test();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            failures++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
        input logic err);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
        chk(32'(e), 32'(err));
    endtask : rd

    task automatic wait_sig(input int s, input logic v, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pick(s) !== v && n < lim);
        if (pick(s) !== v) begin
            failures++;
            end_of_test();
        end
    endtask : wait_sig

    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(cmp_en), 32'h3);
        rd(`SSEM_CTRL_OFS, ctrl(4'h1, 4'h1), 1'b0);
        rd(`SSEM_STATUS_OFS, 32'h0, 1'b0);
        rd(`SSEM_IEN_OFS, 32'h0, 1'b0);
        rd(`SSEM_STATE_OFS, 32'h3, 1'b0);
        rd(12'hFF0, 32'h0, 1'b1);
        apb(1'b1, `SSEM_IEN_OFS, 32'h3);
        supply_low <= 2'h1;
        wait_sig(0, 1'b1, 10);
        @(posedge pclk);
        chk(32'(gpio_hiz), 32'h1);
        supply_low <= 2'h0;
        wait_sig(1, 1'b0, SETTLE);
        rd(`SSEM_STATUS_OFS, 32'h1, 1'b0);
        rd(`SSEM_STATUS_OFS, 32'h0, 1'b0);
        chk(32'(irq), 32'h0);
        chk(32'(por_cnt), 32'h0);
        apb(1'b1, `SSEM_CTRL_OFS, ctrl(4'h1, 4'h3));
        supply_low <= 2'h2;
        wait_sig(0, 1'b1, 10);
        repeat (2) @(posedge pclk);
        supply_low <= 2'h0;
        chk(32'(por_cnt > 0), 32'h1);
        repeat (4) @(posedge pclk);
        rd(`SSEM_STATUS_OFS, 32'h2, 1'b0);
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, `SSEM_CTRL_OFS, ctrl(4'h0, 4'h1));
            supply_low <= 2'h1;
            apb(1'b1, `SSEM_CTRL_OFS, ctrl({1'b0, f[0], 2'h1}, 4'h1));
            wait_sig(0, 1'b1, 400);
            @(posedge pclk);
            lat = irq_rise - en_rise;
            chk(32'(lat >= mask_len(f[0]) &&
                lat <= mask_len(f[0]) + 4), 32'h1);
            supply_low <= 2'h0;
            repeat (4) @(posedge pclk);
            rd(`SSEM_STATUS_OFS, 32'h1, 1'b0);
        end
        apb(1'b1, `SSEM_CTRL_OFS, ctrl(4'h1, 4'h1));
        for (int m = 2; m < 5; m++) begin
            lp_mode <= 3'(m);
            repeat (3 + xs() % 8) @(posedge pclk);
            chk(32'(cmp_en), 32'h0);
            lp_mode <= 3'h0;
            repeat (3) @(posedge pclk);
            chk(32'(cmp_en), 32'h3);
            repeat (HOLD + 5) @(posedge pclk);
        end
        apb(1'b1, `SSEM_CTRL_OFS, ctrl(4'h9, 4'h9));
        lp_mode <= 3'h2 + 3'(xs() % 3);
        repeat (5) @(posedge pclk);
        chk(32'(cmp_en), 32'h3);
        lp_mode <= 3'h0;
        // Let any hold-off from that random wake run out first
        repeat (HOLD + 5) @(posedge pclk);
        // Low side in normal mode holds the CPU after an LPM3 wake
        apb(1'b1, `SSEM_CTRL_OFS, ctrl(4'h1, 4'h1));
        lp_mode <= 3'h3;
        repeat (5) @(posedge pclk);
        lp_mode <= 3'h0;
        wait_sig(2, 1'b1, 10);
        wait_sig(2, 1'b0, HOLD + 5);
        chk(32'(n >= HOLD - 1 && n <= HOLD + 1), 32'h1);
        repeat (MASK_NM + 5) @(posedge pclk);
        apb(1'b1, `SSEM_CTRL_OFS, ctrl(4'h5, 4'h1));
        false_wake <= 1'b1;
        lp_mode <= 3'h2;
        repeat (5) @(posedge pclk);
        chk(32'(cmp_full_perf), 32'h1);
        lp_mode <= 3'h0;
        wait_sig(0, 1'b1, 400);
        @(posedge pclk);
        lat = irq_rise - en_rise;
        chk(32'(lat >= FP_MASK && lat <= FP_MASK + 4), 32'h1);
        false_wake <= 1'b0;
        repeat (SETTLE) @(posedge pclk);
        rd(`SSEM_STATUS_OFS, 32'h1, 1'b0);
        end_of_test();
    end
endmodule : ssem_top_tb
